/* design/sdm_line_field_counter.sv */
// Purpose: Horizontal and vertical position counters of the SD path.
// Assumes: Sync events are single-cycle pulses on the same clock.
// Notes:   In free-running mode the counters clear only on sync events and otherwise wrap at their full width.

`timescale 1ns/1ns
`default_nettype none

module sdm_line_field_counter
#(
    parameter int H_W     = 12,
    parameter int V_W     = 10,
    parameter int H_TOTAL = 858,
    parameter int V_TOTAL = 525
)
(
    input  wire logic           clk,
    input  wire logic           srst,
    input  wire logic           free_run,
    input  wire logic           line_evt,
    input  wire logic           field_evt,
    output var  logic [H_W-1:0] h_cnt_q,
    output var  logic [V_W-1:0] v_cnt_q
);

    localparam logic [H_W-1:0] H_LAST = H_W'(H_TOTAL - 1);
    localparam logic [V_W-1:0] V_LAST = V_W'(V_TOTAL - 1);

    // ----------------------------------------------------------------
    // Horizontal counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            h_cnt_q <= '0;
        else if (free_run && line_evt)
            h_cnt_q <= '0;
        else if (!free_run && h_cnt_q == H_LAST)
            h_cnt_q <= '0;
        else
            h_cnt_q <= h_cnt_q + H_W'(1);
    end

    // ----------------------------------------------------------------
    // Vertical counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            v_cnt_q <= '0;
        else if (free_run)
        begin
            if (field_evt)
                v_cnt_q <= '0;
            else if (line_evt)
                v_cnt_q <= v_cnt_q + V_W'(1);
        end
        else if (h_cnt_q == H_LAST)
        begin
            v_cnt_q <= (v_cnt_q == V_LAST) ? '0 : v_cnt_q + V_W'(1);
        end
    end

endmodule : sdm_line_field_counter

`default_nettype wire

/* design/sdm_mode_regs.sv */
// Purpose: SD mode configuration registers with APB access.
// Assumes: Sync inputs are asynchronous pins, active high.
// Notes:   Reserved bits are held at zero and read back as zero.
//
// How it works
// RL1 - Counter mode 0 wraps at standard length.
// RL2 - Counter mode 1 wraps on external sync.
// RL3 - Auto detect enable follows its bit.
// RL4 - RGB input bit selects colour space.
// RL5 - Software writes zero to reserved bits.
// RL6 - Software writes zero to upper reserved bits.
// RL7 - Noise reduction enable follows its bit.
// RL8 - Gamma enable follows its bit.
// RL9 - Gamma curve select follows its bit.
// RL10 - Black burst replaces luma when set.
// RL11 - Burst start delay chosen by two bits.
//
// Design decision made here: register access over APB.

`timescale 1ns/1ns
`default_nettype none

module sdm_mode_regs
#(
    parameter int H_TOTAL = 858,
    parameter int V_TOTAL = 525
)
(
    input  wire logic                        CLOCK,
    input  wire logic                        SRST,
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [sdm_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [31:0]                 PWDATA,
    output var  logic [31:0]                 PRDATA,
    output var  logic                        PREADY,
    output var  logic                        PSLVERR,
    input  wire logic                        HSYNC_IN,
    input  wire logic                        VSYNC_IN,
    output var  logic                        RGB_COLOR_SWAP,
    output var  logic                        COUNTER_FREE_RUN,
    output var  logic                        SYNC_861_EN,
    output var  logic                        PRPB_SCALE_EN,
    output var  logic                        Y_SCALE_EN,
    output var  logic                        HUE_ADJUST_EN,
    output var  logic                        BRIGHTNESS_EN,
    output var  logic                        LUMA_SHAPING_FILTER_GAIN_EN,
    output var  logic                        AUTO_DETECT_EN,
    output var  logic                        RGB_INPUT_EN,
    output var  logic                        NONINTERLACED_EN,
    output var  logic                        DOUBLE_BUFFER_EN,
    output var  logic [1:0]                  INPUT_FORMAT,
    output var  logic                        NOISE_REDUCTION_EN,
    output var  logic                        GAMMA_EN,
    output var  logic                        GAMMA_CURVE_B,
    output var  logic [1:0]                  UNDERSHOOT_LIMIT,
    output var  logic                        LUMA_BLACK_BURST,
    output var  logic [1:0]                  CHROMA_DELAY,
    output var  logic [sdm_pkg::H_W-1:0]     H_COUNT,
    output var  logic [sdm_pkg::V_W-1:0]     V_COUNT,
    output var  logic                        BURST_START
);

    import sdm_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]     sync_ctrl_q;
    logic [7:0]     pic_adj_q;
    logic [7:0]     in_gamma_q;
    logic [7:0]     lim_cdly_q;
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;
    logic           burst_q;
    logic [1:0]     sync_meta_q;
    logic [1:0]     sync_sync_q;
    logic [1:0]     sync_prev_q;
    logic           line_evt;
    logic           field_evt;
    logic           setup;
    logic           wr_fire;
    logic [9:0]     idx;
    logic           aligned;
    logic           hit_sync;
    logic           hit_pic;
    logic           hit_gam;
    logic           hit_lim;
    logic           mapped;
    logic [7:0]     rd_mux;
    logic [1:0]     burst_sel;
    logic [H_W-1:0] burst_cmp;
    logic [H_W-1:0] h_cnt;
    logic [V_W-1:0] v_cnt;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign idx      = PADDR[ADDR_W-1:2];
    assign aligned  = (PADDR[1:0] == 2'h0);
    assign hit_sync = aligned && (idx == IDX_SYNC_CTRL);
    assign hit_pic  = aligned && (idx == IDX_PIC_ADJ);
    assign hit_gam  = aligned && (idx == IDX_IN_GAMMA);
    assign hit_lim  = aligned && (idx == IDX_LIM_CDLY);
    assign mapped   = hit_sync || hit_pic || hit_gam || hit_lim;
    assign setup    = PSEL && !PENABLE;
    assign wr_fire  = PSEL && PENABLE && pready_q && PWRITE;
    assign rd_mux   = ({8{hit_sync}} & sync_ctrl_q)
                    | ({8{hit_pic}}  & pic_adj_q)
                    | ({8{hit_gam}}  & in_gamma_q)
                    | ({8{hit_lim}}  & lim_cdly_q);

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    // Answer one cycle after setup: no wait states, data stable.
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            prdata_q  <= (setup && !PWRITE) ? {24'h00_0000, rd_mux}
                                            : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Masking keeps a careless write off the datapath.
    // RL5 reserved bits masked
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            sync_ctrl_q <= RST_SYNC_CTRL;
        else if (wr_fire && hit_sync)
            sync_ctrl_q <= PWDATA[7:0] & MSK_SYNC_CTRL;
    end

    // RL3 auto detect storage
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            pic_adj_q <= RST_PIC_ADJ;
        else if (wr_fire && hit_pic)
            pic_adj_q <= PWDATA[7:0] & MSK_PIC_ADJ;
    end

    // RL7 noise reduction storage
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            in_gamma_q <= RST_IN_GAMMA;
        else if (wr_fire && hit_gam)
            in_gamma_q <= PWDATA[7:0] & MSK_IN_GAMMA;
    end

    // RL6 upper bits masked
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            lim_cdly_q <= RST_LIM_CDLY;
        else if (wr_fire && hit_lim)
            lim_cdly_q <= PWDATA[7:0] & MSK_LIM_CDLY;
    end

    // ----------------------------------------------------------------
    // Sync input capture
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            sync_meta_q <= 2'h0;
            sync_sync_q <= 2'h0;
            sync_prev_q <= 2'h0;
        end
        else
        begin
            sync_meta_q <= {VSYNC_IN, HSYNC_IN};
            sync_sync_q <= sync_meta_q;
            sync_prev_q <= sync_sync_q;
        end
    end

    assign line_evt  = sync_sync_q[0] && !sync_prev_q[0];
    assign field_evt = sync_sync_q[1] && !sync_prev_q[1];

    // ----------------------------------------------------------------
    // Position counters
    // ----------------------------------------------------------------
    // RL1 self wrap mode
    // RL2 sync wrap mode
    sdm_line_field_counter
    #(
        .H_W     (H_W),
        .V_W     (V_W),
        .H_TOTAL (H_TOTAL),
        .V_TOTAL (V_TOTAL)
    )
    u_counter
    (
        .clk       (CLOCK),
        .srst      (SRST),
        .free_run  (sync_ctrl_q[BIT_FREE_RUN]),
        .line_evt  (line_evt),
        .field_evt (field_evt),
        .h_cnt_q   (h_cnt),
        .v_cnt_q   (v_cnt)
    );

    // ----------------------------------------------------------------
    // Burst start timing
    // ----------------------------------------------------------------
    // Count zero is the line wrap in counted mode, or the detected hsync rising edge in free-running mode; compare one early.
    assign burst_sel = sync_ctrl_q[BIT_BURST_SEL_LO +: 2];

    always_comb
    begin
        case (burst_sel)
            2'h0:    burst_cmp = H_W'(BURST_A_CYC - 1);
            2'h1:    burst_cmp = H_W'(BURST_B_CYC - 1);
            2'h2:    burst_cmp = H_W'(BURST_C_CYC - 1);
            default: burst_cmp = '0;
        endcase
    end

    // RL11 burst start pulse
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            burst_q <= 1'b0;
        else
            burst_q <= (burst_sel != BURST_SEL_RSVD) && (h_cnt == burst_cmp);
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PRDATA                      = prdata_q;
    assign PREADY                      = pready_q;
    assign PSLVERR                     = pslverr_q;
    assign RGB_COLOR_SWAP              = sync_ctrl_q[BIT_COLOR_SWAP];
    assign COUNTER_FREE_RUN            = sync_ctrl_q[BIT_FREE_RUN];
    assign SYNC_861_EN                 = sync_ctrl_q[BIT_SYNC_861];
    assign PRPB_SCALE_EN               = pic_adj_q[BIT_PRPB_SCALE];
    assign Y_SCALE_EN                  = pic_adj_q[BIT_Y_SCALE];
    assign HUE_ADJUST_EN               = pic_adj_q[BIT_HUE];
    assign BRIGHTNESS_EN               = pic_adj_q[BIT_BRIGHT];
    assign LUMA_SHAPING_FILTER_GAIN_EN = pic_adj_q[BIT_SHAPING_GAIN];
    // RL3 auto detect out
    assign AUTO_DETECT_EN              = pic_adj_q[BIT_AUTO_DETECT];
    // RL4 colour space out
    assign RGB_INPUT_EN                = pic_adj_q[BIT_RGB_INPUT];
    assign NONINTERLACED_EN            = in_gamma_q[BIT_NONINTERLACED];
    assign DOUBLE_BUFFER_EN            = in_gamma_q[BIT_DOUBLE_BUF];
    assign INPUT_FORMAT                = in_gamma_q[BIT_IN_FORMAT_LO +: 2];
    // RL7 noise reduction out
    assign NOISE_REDUCTION_EN          = in_gamma_q[BIT_NOISE_RED];
    // RL8 gamma enable out
    assign GAMMA_EN                    = in_gamma_q[BIT_GAMMA_EN];
    // RL9 gamma curve out
    assign GAMMA_CURVE_B               = in_gamma_q[BIT_GAMMA_CURVE];
    assign UNDERSHOOT_LIMIT            = lim_cdly_q[BIT_UNDERSHOOT_LO +: 2];
    // RL10 black burst out
    assign LUMA_BLACK_BURST            = lim_cdly_q[BIT_BLACK_BURST];
    assign CHROMA_DELAY                = lim_cdly_q[BIT_CHROMA_DLY_LO +: 2];
    assign H_COUNT                     = h_cnt;
    assign V_COUNT                     = v_cnt;
    assign BURST_START                 = burst_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    localparam logic [H_W-1:0] H_LAST = H_W'(H_TOTAL - 1);
    localparam logic [V_W-1:0] V_LAST = V_W'(V_TOTAL - 1);
    localparam logic [H_W-1:0] BURST_A_AT = H_W'(BURST_A_CYC - 1);

    property p_rl1_hwrap;
        !COUNTER_FREE_RUN && H_COUNT == H_LAST |=> H_COUNT == '0;
    endproperty
    a_rl1_hwrap: assert property (p_rl1_hwrap) // RL1
        else $error("Line counter did not wrap at line end.");
    property p_rl1_vwrap;
        !COUNTER_FREE_RUN && H_COUNT == H_LAST && V_COUNT == V_LAST
            |=> V_COUNT == '0;
    endproperty
    a_rl1_vwrap: assert property (p_rl1_vwrap) // RL1
        else $error("Field counter did not wrap at field end.");
    property p_rl2_sync;
        COUNTER_FREE_RUN && line_evt |=> H_COUNT == '0;
    endproperty
    a_rl2_sync: assert property (p_rl2_sync) // RL2
        else $error("Free counter ignored line sync.");
    property p_rl2_free;
        COUNTER_FREE_RUN && !line_evt && H_COUNT == H_LAST
            |=> H_COUNT == H_LAST + H_W'(1);
    endproperty
    a_rl2_free: assert property (p_rl2_free) // RL2
        else $error("Free counter wrapped without sync.");
    property p_rl3_auto;
        wr_fire && hit_pic |=> AUTO_DETECT_EN == $past(PWDATA[5]);
    endproperty
    a_rl3_auto: assert property (p_rl3_auto) // RL3
        else $error("Auto detect enable did not follow write.");
    property p_rl4_rgb;
        wr_fire && hit_pic |=> RGB_INPUT_EN == $past(PWDATA[7]);
    endproperty
    a_rl4_rgb: assert property (p_rl4_rgb) // RL4
        else $error("Colour space select did not follow write.");
    property p_rl7_dnr;
        wr_fire && hit_gam |=> NOISE_REDUCTION_EN == $past(PWDATA[5]);
    endproperty
    a_rl7_dnr: assert property (p_rl7_dnr) // RL7
        else $error("Noise reduction enable did not follow write.");
    property p_rl8_gamma;
        wr_fire && hit_gam |=> GAMMA_EN == $past(PWDATA[6])
            ##1 $stable(GAMMA_EN) || $past(wr_fire);
    endproperty
    a_rl8_gamma: assert property (p_rl8_gamma) // RL8
        else $error("Gamma enable did not follow write.");
    property p_rl9_curve;
        wr_fire && hit_gam |=> GAMMA_CURVE_B == $past(PWDATA[7]);
    endproperty
    a_rl9_curve: assert property (p_rl9_curve) // RL9
        else $error("Gamma curve select did not follow write.");
    property p_rl10_black;
        wr_fire && hit_lim |=> LUMA_BLACK_BURST == $past(PWDATA[3]);
    endproperty
    a_rl10_black: assert property (p_rl10_black) // RL10
        else $error("Black burst enable did not follow write.");
    property p_rl11_burst;
        burst_sel == 2'h0 && H_COUNT == BURST_A_AT |=> BURST_START;
    endproperty
    a_rl11_burst: assert property (p_rl11_burst) // RL11
        else $error("Burst start missing at shortest delay.");
    property p_rl11_rsvd;
        burst_sel == BURST_SEL_RSVD |=> !BURST_START;
    endproperty
    a_rl11_rsvd: assert property (p_rl11_rsvd) // RL11
        else $error("Burst start raised on reserved setting.");

    c_write: cover property (wr_fire && hit_gam);
    c_free_sync: cover property (COUNTER_FREE_RUN && line_evt);
    c_burst: cover property (BURST_START);
    c_unmapped: cover property (PSLVERR && PREADY);

endmodule : sdm_mode_regs

`default_nettype wire

/* design/sdm_pkg.sv */
// Purpose: Shared constants for the SD mode configuration register bank.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes:   Register indices are scaled by four to form byte addresses.

`default_nettype none

package sdm_pkg;

    // ----------------------------------------------------------------
    // Register indices and widths
    // ----------------------------------------------------------------
    localparam int          ADDR_W        = 12;
    localparam int          REG_W         = 8;
    localparam logic [9:0]  IDX_SYNC_CTRL = 10'h086;
    localparam logic [9:0]  IDX_PIC_ADJ   = 10'h087;
    localparam logic [9:0]  IDX_IN_GAMMA  = 10'h088;
    localparam logic [9:0]  IDX_LIM_CDLY  = 10'h089;

    // ----------------------------------------------------------------
    // Reset values and writable bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_SYNC_CTRL = 8'h02;
    localparam logic [7:0]  RST_PIC_ADJ   = 8'h00;
    localparam logic [7:0]  RST_IN_GAMMA  = 8'h00;
    localparam logic [7:0]  RST_LIM_CDLY  = 8'h00;
    localparam logic [7:0]  MSK_SYNC_CTRL = 8'hCB;
    localparam logic [7:0]  MSK_PIC_ADJ   = 8'hBF;
    localparam logic [7:0]  MSK_IN_GAMMA  = 8'hFE;
    localparam logic [7:0]  MSK_LIM_CDLY  = 8'h3B;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_BURST_SEL_LO  = 0;
    localparam int BIT_SYNC_861      = 3;
    localparam int BIT_FREE_RUN      = 6;
    localparam int BIT_COLOR_SWAP    = 7;
    localparam int BIT_PRPB_SCALE    = 0;
    localparam int BIT_Y_SCALE       = 1;
    localparam int BIT_HUE           = 2;
    localparam int BIT_BRIGHT        = 3;
    localparam int BIT_SHAPING_GAIN  = 4;
    localparam int BIT_AUTO_DETECT   = 5;
    localparam int BIT_RGB_INPUT     = 7;
    localparam int BIT_NONINTERLACED = 1;
    localparam int BIT_DOUBLE_BUF    = 2;
    localparam int BIT_IN_FORMAT_LO  = 3;
    localparam int BIT_NOISE_RED     = 5;
    localparam int BIT_GAMMA_EN      = 6;
    localparam int BIT_GAMMA_CURVE   = 7;
    localparam int BIT_UNDERSHOOT_LO = 0;
    localparam int BIT_BLACK_BURST   = 3;
    localparam int BIT_CHROMA_DLY_LO = 4;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int BURST_A_NS     = 5170;
    localparam int BURST_B_NS     = 5310;
    localparam int BURST_C_NS     = 5590;
    localparam int BURST_A_CYC    =
        (BURST_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURST_B_CYC    =
        (BURST_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURST_C_CYC    =
        (BURST_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] BURST_SEL_RSVD = 2'h3;

    // ----------------------------------------------------------------
    // Counter defaults
    // ----------------------------------------------------------------
    localparam int H_W       = 12;
    localparam int V_W       = 10;
    localparam int H_TOTAL   = 858;
    localparam int V_TOTAL   = 525;

endpackage : sdm_pkg

`default_nettype wire

/* test/sdm_mode_regs_tb.sv */
// Purpose: Self-checking bench for the SD mode register bank.
// Assumes: One-cycle APB answer; reserved bits are written as zero.
// Notes:   Sampling at each rising edge sees settled pre-edge values.
`timescale 1ns/1ns
`default_nettype none
module sdm_mode_regs_tb;
    import sdm_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        hsync = 1'b0;
    logic        vsync = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, free_run, auto_det, rgb_in, noise_red;
    logic        gamma_en, gamma_b, black_burst, burst_start;
    logic [11:0] h_count;
    logic [9:0]  v_count;
    wire  [1:0]  sync_o;
    wire  [4:0]  pic_o;
    wire  [3:0]  gam_o;
    wire  [3:0]  lim_o;
    // A short field lets the field wrap occur within the run.
    localparam int FIELD_LINES = 3;
    int          error_cnt = 0;
    int          tests_run = 0;
    logic [31:0] rd;
    logic        err;
    int          n;
    logic [9:0]  v0;
    logic [7:0]  m;
    sdm_mode_regs #(.V_TOTAL(FIELD_LINES)) dut_u (.CLOCK(clock),
        .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .HSYNC_IN(hsync), .VSYNC_IN(vsync),
        .RGB_COLOR_SWAP(sync_o[1]), .COUNTER_FREE_RUN(free_run),
        .SYNC_861_EN(sync_o[0]), .PRPB_SCALE_EN(pic_o[0]),
        .Y_SCALE_EN(pic_o[1]), .HUE_ADJUST_EN(pic_o[2]),
        .BRIGHTNESS_EN(pic_o[3]), .LUMA_SHAPING_FILTER_GAIN_EN(pic_o[4]),
        .AUTO_DETECT_EN(auto_det), .RGB_INPUT_EN(rgb_in),
        .NONINTERLACED_EN(gam_o[0]), .DOUBLE_BUFFER_EN(gam_o[1]),
        .INPUT_FORMAT(gam_o[3:2]),
        .NOISE_REDUCTION_EN(noise_red), .GAMMA_EN(gamma_en),
        .GAMMA_CURVE_B(gamma_b), .UNDERSHOOT_LIMIT(lim_o[1:0]),
        .LUMA_BLACK_BURST(black_burst), .CHROMA_DELAY(lim_o[3:2]),
        .H_COUNT(h_count), .V_COUNT(v_count), .BURST_START(burst_start));
    always #20 clock = ~clock;
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, {24'h0, e});
        chk({31'h0, err}, 32'h0);
    endtask : rd_chk
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------
    // Watchdog, sized well above the longest path of the tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (30000) @(posedge clock);
        error_cnt++;
        complete_run;
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        rd_chk(12'h218, 8'h02);
        rd_chk(12'h21C, 8'h00);
        rd_chk(12'h220, 8'h00);
        rd_chk(12'h224, 8'h00);
        // Unmapped place is refused and reads zero.
        apb(1'b0, 12'h300, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            // Reserved bits stay zero in every write.
            m = i ? 8'hBF : 8'h00;
            apb(1'b1, 12'h21C, {24'h0, m});
            m = i ? 8'hFE : 8'h00;
            apb(1'b1, 12'h220, {24'h0, m});
            m = i ? 8'h3B : 8'h00;
            apb(1'b1, 12'h224, {24'h0, m});
            m = i ? 8'h88 : 8'h00;
            apb(1'b1, 12'h218, {24'h0, m});
            @(posedge clock);
            chk({31'h0, auto_det}, i);
            chk({31'h0, rgb_in}, i);
            chk({31'h0, noise_red}, i);
            chk({31'h0, gamma_en}, i);
            chk({31'h0, gamma_b}, i);
            chk({31'h0, black_burst}, i);
            chk({30'h0, sync_o}, i ? 32'h3 : 32'h0);
            chk({27'h0, pic_o}, i ? 32'h1F : 32'h0);
            chk({28'h0, gam_o}, i ? 32'hF : 32'h0);
            chk({28'h0, lim_o}, i ? 32'hF : 32'h0);
            rd_chk(12'h220, i ? 8'hFE : 8'h00);
        end
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, 12'h218, s);
            n = 0;
            do
            begin
                @(posedge clock);
                n++;
            end
            while (burst_start !== 1'b1 && n < 900);
            if (s == 3)
                chk(n, 900);
            else
                chk(h_count, s == 0 ? 130 : s == 1 ? 133 : 140);
        end
        // Counted mode wraps at the line length; sync is ignored.
        hsync <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (h_count !== H_TOTAL - 1 && n < 900);
        v0 = v_count;
        @(posedge clock);
        chk(h_count, 0);
        chk(v_count, (v0 + 1) % FIELD_LINES);
        hsync <= 1'b0;
        // Free-running counters pass the line length and wrap on sync.
        apb(1'b1, 12'h218, 32'h42);
        @(posedge clock);
        chk({31'h0, free_run}, 1);
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (h_count !== H_TOTAL && n < 1000);
        chk(h_count, H_TOTAL);
        hsync <= 1'b1;
        vsync <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (h_count !== 12'h000 && n < 6);
        chk(n < 6, 1);
        chk(v_count, 0);
        complete_run;
    end
endmodule : sdm_mode_regs_tb
`default_nettype wire
